// ===== design/awh_area_timing.sv
// external area access sequencer with programmable wait and strobe-to-select hold
// What this block does
// - wait codes 1010, 1011, 1100 insert 14, 18 and 24 access wait cycles.
// - mask bit 6 resets to 0; 0 honours external wait, 1 ignores it.
// - mask setting applies even with zero programmed wait cycles.
// - bits 5 to 2 read as zero; software writes zeros there.
// - hold field resets 0; code 00 gives 0.5, 01 gives 1.5 cycles.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module awh_area_timing #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16
) (
    // clock and reset
    input  wire logic              CLOCK_I,
    input  wire logic              RESET_N_I,
    // register port
    input  wire logic [3:0]        REG_ADDR_I,
    input  wire logic [31:0]       REG_WDATA_I,
    input  wire logic              REG_WR_I,
    input  wire logic              REG_RD_I,
    output logic      [31:0]       REG_RDATA_O,
    // access request from the internal master
    input  wire logic              ACC_REQ_I,
    input  wire logic              ACC_WRITE_I,
    input  wire logic [ADDR_W-1:0] ACC_ADDR_I,
    input  wire logic [DATA_W-1:0] ACC_WDATA_I,
    input  wire logic [1:0]        ACC_BE_I,
    output logic                   ACC_BUSY_O,
    output logic                   ACC_DONE_O,
    output logic      [DATA_W-1:0] ACC_RDATA_O,
    // external bus
    output logic      [ADDR_W-1:0] EXT_ADDR_O,
    output logic                   AREA_SELECT_N_O,
    output logic                   READ_STROBE_N_O,
    output logic                   WRITE_STROBE_N_O,
    output logic      [1:0]        BYTE_LANE_STROBE_N_O,
    output logic      [DATA_W-1:0] EXT_DATA_O,
    output logic                   EXT_DATA_OE_O,
    input  wire logic [DATA_W-1:0] EXT_DATA_I,
    input  wire logic              EXT_WAIT_N_I
);
    logic [3:0] wait_code_q;
    logic external_wait_mask_q;
    logic [1:0] strobe_to_select_hold_q;
    awh_pkg::awh_state_t state_q;
    awh_pkg::awh_req_t req_q;
    logic [4:0] wait_cnt_q;
    logic [1:0] hold_cnt_q;
    logic select_n_q;
    logic busy_q;
    logic done_q;
    logic rd_strobe_n_q;
    logic wr_strobe_n_q;
    logic [1:0] be_strobe_n_q;
    logic data_oe_q;
    logic [DATA_W-1:0] rdata_q;
    logic [31:0] reg_rdata_q;
    logic [ADDR_W-1:0] ext_addr_q;
    logic ext_select_n_q;
    logic [4:0] wait_cycles;
    logic wait_held;
    logic start;
    logic hold_none;

    // lower codes are linear; reserved codes saturate at the longest count
    function automatic logic [4:0] wait_of(input logic [3:0] code);
        logic [4:0] n;
        n = {1'b0, code};
        case (code)
            awh_pkg::AWH_WC_6:  n = awh_pkg::AWH_CNT_6;
            awh_pkg::AWH_WC_8:  n = awh_pkg::AWH_CNT_8;
            awh_pkg::AWH_WC_10: n = awh_pkg::AWH_CNT_10;
            awh_pkg::AWH_WC_12: n = awh_pkg::AWH_CNT_12;
            awh_pkg::AWH_WC_14: n = awh_pkg::AWH_CNT_14;
            awh_pkg::AWH_WC_18: n = awh_pkg::AWH_CNT_18;
            awh_pkg::AWH_WC_24: n = awh_pkg::AWH_WAIT_MAX;
            default: begin
                if (code > awh_pkg::AWH_WC_24) begin
                    n = awh_pkg::AWH_WAIT_MAX;
                end
            end
        endcase
        return n;
    endfunction

    assign wait_cycles = wait_of(wait_code_q);
    // wait is looked at even when no wait cycles are programmed
    assign wait_held = !external_wait_mask_q && !EXT_WAIT_N_I;
    // a request is taken only when idle; one arriving while busy is dropped
    assign start = ACC_REQ_I && (state_q == awh_pkg::AWH_IDLE);
    // code 00 has no whole hold cycle, only the half cycle of the falling-edge stage
    assign hold_none = strobe_to_select_hold_q == 2'h0;

    // configuration register
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            wait_code_q <= awh_pkg::AWH_WAIT_RST;
            external_wait_mask_q <= awh_pkg::AWH_MASK_RST;
            strobe_to_select_hold_q <= awh_pkg::AWH_HOLD_RST;
        end else if (REG_WR_I && REG_ADDR_I == awh_pkg::AWH_OFS_TIMING) begin
            // reserved bits 5 to 2 have no storage, so written ones are dropped
            wait_code_q <= REG_WDATA_I[awh_pkg::AWH_WAIT_MSB:awh_pkg::AWH_WAIT_LSB];
            external_wait_mask_q <= REG_WDATA_I[awh_pkg::AWH_MASK_BIT];
            strobe_to_select_hold_q <= REG_WDATA_I[awh_pkg::AWH_HOLD_MSB:awh_pkg::AWH_HOLD_LSB];
        end
    end

    // read data stand one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            reg_rdata_q <= 32'h0;
        end else begin
            reg_rdata_q <= 32'h0;
            if (REG_RD_I && REG_ADDR_I == awh_pkg::AWH_OFS_TIMING) begin
                reg_rdata_q[awh_pkg::AWH_WAIT_MSB:awh_pkg::AWH_WAIT_LSB] <= wait_code_q;
                reg_rdata_q[awh_pkg::AWH_MASK_BIT] <= external_wait_mask_q;
                reg_rdata_q[awh_pkg::AWH_RSVD_MSB:awh_pkg::AWH_RSVD_LSB] <= 4'h0;
                reg_rdata_q[awh_pkg::AWH_HOLD_MSB:awh_pkg::AWH_HOLD_LSB] <= strobe_to_select_hold_q;
            end else if (REG_RD_I && REG_ADDR_I == awh_pkg::AWH_OFS_STATUS) begin
                // the raw wait pin is shown so that a stuck device can be seen
                reg_rdata_q[0] <= busy_q;
                reg_rdata_q[2:1] <= state_q;
                reg_rdata_q[3] <= !EXT_WAIT_N_I;
            end
        end
    end

    // access sequencer
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q <= awh_pkg::AWH_IDLE;
            req_q <= '0;
            wait_cnt_q <= 5'h0;
            hold_cnt_q <= 2'h0;
            select_n_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rd_strobe_n_q <= 1'b1;
            wr_strobe_n_q <= 1'b1;
            be_strobe_n_q <= 2'h3;
            data_oe_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                awh_pkg::AWH_IDLE: begin
                    if (start) begin
                        req_q <= '{write: ACC_WRITE_I, addr: ACC_ADDR_I, wdata: ACC_WDATA_I, be: ACC_BE_I};
                        wait_cnt_q <= wait_cycles;
                        select_n_q <= 1'b0;
                        busy_q <= 1'b1;
                        rd_strobe_n_q <= ACC_WRITE_I;
                        wr_strobe_n_q <= !ACC_WRITE_I;
                        be_strobe_n_q <= ~ACC_BE_I;
                        data_oe_q <= ACC_WRITE_I;
                        state_q <= awh_pkg::AWH_STROBE;
                    end
                end
                awh_pkg::AWH_STROBE: begin
                    if (wait_cnt_q != 5'h0) begin
                        wait_cnt_q <= wait_cnt_q - 5'h1;
                    end else if (!wait_held) begin
                        rd_strobe_n_q <= 1'b1;
                        wr_strobe_n_q <= 1'b1;
                        be_strobe_n_q <= 2'h3;
                        rdata_q <= EXT_DATA_I;
                        // code 00 lets select go now, so the pin follows half a cycle after the strobe
                        if (hold_none) begin
                            select_n_q <= 1'b1;
                        end
                        hold_cnt_q <= strobe_to_select_hold_q;
                        state_q <= awh_pkg::AWH_HOLD;
                    end
                end
                awh_pkg::AWH_HOLD: begin
                    if (hold_cnt_q != 2'h0) begin
                        hold_cnt_q <= hold_cnt_q - 2'h1;
                        // each whole hold cycle adds one cycle before select lets go
                        if (hold_cnt_q == 2'h1) begin
                            select_n_q <= 1'b1;
                        end
                    end else begin
                        // data stay driven half a cycle past select, keeping write hold on the bus
                        data_oe_q <= 1'b0;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= awh_pkg::AWH_IDLE;
                    end
                end
                default: begin
                    state_q <= awh_pkg::AWH_IDLE;
                end
            endcase
        end
    end

    // falling-edge stage gives address and select their half-cycle offset
    always_ff @(negedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ext_addr_q <= '0;
            ext_select_n_q <= 1'b1;
        end else begin
            ext_addr_q <= req_q.addr;
            ext_select_n_q <= select_n_q;
        end
    end

    assign REG_RDATA_O = reg_rdata_q;
    assign ACC_BUSY_O = busy_q;
    assign ACC_DONE_O = done_q;
    assign ACC_RDATA_O = rdata_q;
    assign EXT_ADDR_O = ext_addr_q;
    assign AREA_SELECT_N_O = ext_select_n_q;
    assign READ_STROBE_N_O = rd_strobe_n_q;
    assign WRITE_STROBE_N_O = wr_strobe_n_q;
    assign BYTE_LANE_STROBE_N_O = be_strobe_n_q;
    assign EXT_DATA_O = req_q.wdata;
    assign EXT_DATA_OE_O = data_oe_q;
endmodule

// ===== design/awh_pkg.sv
// shared constants and types of the area wait and hold timing block
package awh_pkg;
    // register offsets
    localparam logic [3:0] AWH_OFS_TIMING = 4'h0;
    localparam logic [3:0] AWH_OFS_STATUS = 4'h4;
    // timing register field positions
    localparam int AWH_WAIT_LSB = 8;
    localparam int AWH_WAIT_MSB = 11;
    localparam int AWH_MASK_BIT = 6;
    localparam int AWH_RSVD_LSB = 2;
    localparam int AWH_RSVD_MSB = 5;
    localparam int AWH_HOLD_LSB = 0;
    localparam int AWH_HOLD_MSB = 1;
    // reset values
    localparam logic [3:0] AWH_WAIT_RST = 4'h0;
    localparam logic AWH_MASK_RST = 1'b0;
    localparam logic [1:0] AWH_HOLD_RST = 2'h0;
    // wait codes with a documented count
    localparam logic [3:0] AWH_WC_6 = 4'h6;
    localparam logic [3:0] AWH_WC_8 = 4'h7;
    localparam logic [3:0] AWH_WC_10 = 4'h8;
    localparam logic [3:0] AWH_WC_12 = 4'h9;
    localparam logic [3:0] AWH_WC_14 = 4'ha;
    localparam logic [3:0] AWH_WC_18 = 4'hb;
    localparam logic [3:0] AWH_WC_24 = 4'hc;
    localparam logic [4:0] AWH_WAIT_MAX = 5'h18;
    // access wait cycles of the documented codes
    localparam logic [4:0] AWH_CNT_6 = 5'h06;
    localparam logic [4:0] AWH_CNT_8 = 5'h08;
    localparam logic [4:0] AWH_CNT_10 = 5'h0a;
    localparam logic [4:0] AWH_CNT_12 = 5'h0c;
    localparam logic [4:0] AWH_CNT_14 = 5'h0e;
    localparam logic [4:0] AWH_CNT_18 = 5'h12;

    typedef enum logic [1:0] {
        AWH_IDLE   = 2'b00,
        AWH_STROBE = 2'b01,
        AWH_HOLD   = 2'b10
    } awh_state_t;

    typedef struct packed {
        logic        write;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [1:0]  be;
    } awh_req_t;
endpackage

// ===== verif/awh_area_timing_properties.sv
// checker of wait count, wait mask and hold timing at the block's ports
`timescale 1ns/1ps
module awh_area_timing_properties (
    // clock, reset and register port
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    // external bus
    input wire logic READ_STROBE_N_O,
    input wire logic WRITE_STROBE_N_O,
    input wire logic AREA_SELECT_N_O,
    input wire logic EXT_WAIT_N_I
);
    logic [3:0] wc_q;
    logic mask_q;
    logic [1:0] hold_q;
    logic [7:0] cnt_q;
    wire stb_lo = !(READ_STROBE_N_O && WRITE_STROBE_N_O);
    // shadow of the timing register plus a count of strobe-low cycles
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            wc_q <= 4'h0;
            mask_q <= 1'b0;
            hold_q <= 2'h0;
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= stb_lo ? cnt_q + 8'h01 : 8'h00;
            if (REG_WR_I && REG_ADDR_I == awh_pkg::AWH_OFS_TIMING) begin
                wc_q <= REG_WDATA_I[11:8];
                mask_q <= REG_WDATA_I[6];
                hold_q <= REG_WDATA_I[1:0];
            end
        end
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_strobe_end;
        $rose(!stb_lo);
    endsequence
    property p_cfg_read_back;
        REG_RD_I && REG_ADDR_I == 4'h0 |=> REG_RDATA_O[6] == mask_q && REG_RDATA_O[1:0] == hold_q
            && REG_RDATA_O[11:8] == wc_q;
    endproperty
    property p_wait_count_table;
        s_strobe_end ##0 (mask_q && wc_q inside {4'ha, 4'hb, 4'hc})
            |-> cnt_q == (wc_q == 4'ha ? 8'h0f : wc_q == 4'hb ? 8'h13 : 8'h19);
    endproperty
    property p_hold_one_half;
        s_strobe_end ##0 hold_q == 2'h1 |-> !AREA_SELECT_N_O ##1 $rose(AREA_SELECT_N_O);
    endproperty
    a_rsvd_read_zero: assert property (REG_RD_I && REG_ADDR_I == 4'h0 |=> REG_RDATA_O[5:2] == 4'h0)
        else $error("reserved bits read nonzero");
    a_cfg_read_back: assert property (p_cfg_read_back)
        else $error("mask or hold reads wrong");
    a_wait_count_table: assert property (p_wait_count_table)
        else $error("strobe length wrong for wait code");
    a_masked_zero_wait: assert property (s_strobe_end ##0 (mask_q && wc_q == 4'h0) |-> cnt_q == 8'h01)
        else $error("masked wait still stretched access");
    a_zero_wait_stretch: assert property (stb_lo && !mask_q && !EXT_WAIT_N_I && wc_q == 4'h0 |=> stb_lo)
        else $error("zero-wait access not stretched");
    a_ext_wait_extends: assert property (stb_lo && !mask_q && !EXT_WAIT_N_I |=> stb_lo)
        else $error("strobe ended while wait held");
    a_hold_half: assert property (s_strobe_end ##0 hold_q == 2'h0 |-> $rose(AREA_SELECT_N_O))
        else $error("select not negated half cycle after strobe");
    a_hold_one_half: assert property (p_hold_one_half)
        else $error("select not negated 1.5 cycles after strobe");
endmodule
bind awh_area_timing awh_area_timing_properties i_awh_area_timing_properties (.*);

// ===== verif/awh_area_timing_test.sv
// self-checking bench of the area wait and hold timing block
`timescale 1ns/1ps
module awh_area_timing_test;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0, acc_wr = 1'b0;
    logic done, sel_n, rd_n, wr_n, wait_n, busy, oe;
    logic [1:0] be_n;
    logic [23:0] ext_addr;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] ext_in, acc_rdata, ext_out;
    logic [7:0] stall = 8'h00;
    int num_errors = 0, checks_done = 0, cycles = 0;
    realtime t_stb = 0, t_sel = 0;
    always #20 clk = ~clk;
    awh_area_timing i_awh_area_timing (.CLOCK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .ACC_REQ_I(req), .ACC_WRITE_I(acc_wr),
        .ACC_ADDR_I(24'h001234), .ACC_WDATA_I(16'ha5c3), .ACC_BE_I(2'h3), .ACC_BUSY_O(busy), .ACC_DONE_O(done),
        .ACC_RDATA_O(acc_rdata), .EXT_ADDR_O(ext_addr), .AREA_SELECT_N_O(sel_n), .READ_STROBE_N_O(rd_n),
        .WRITE_STROBE_N_O(wr_n), .BYTE_LANE_STROBE_N_O(be_n), .EXT_DATA_O(ext_out), .EXT_DATA_OE_O(oe),
        .EXT_DATA_I(ext_in), .EXT_WAIT_N_I(wait_n));
    awh_ext_device i_awh_ext_device (.clk_i(clk), .select_n_i(sel_n), .strobe_n_i(rd_n & wr_n),
        .stall_i(stall), .value_i(16'h5a3c), .data_o(ext_in), .wait_n_o(wait_n));
    always @(posedge rd_n or posedge wr_n) t_stb = $realtime;
    always @(posedge sel_n) t_sel = $realtime;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    // strobe length, strobe-to-select hold and read data of one access
    task automatic access(input logic w, input logic [3:0] wc, input logic m, input logic [1:0] hc,
        input logic [7:0] st, input logic [7:0] len);
        int n;
        n = 0;
        reg_wr(4'h0, {20'h0, wc, 1'b0, m, 4'h0, hc});
        req <= 1'b1;
        acc_wr <= w;
        stall <= st;
        @(posedge clk);
        req <= 1'b0;
        for (int k = 0; k < 200; k++) begin
            #1;
            if (done === 1'b1) break;
            if (!(rd_n && wr_n)) n++;
            if (n == 1 && !(rd_n && wr_n)) begin
                check({31'h0, busy}, 32'h1);
                check({30'h0, be_n}, 32'h0);
                check({31'h0, oe}, {31'h0, w});
            end
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
        check(32'(n), 32'(len));
        check(32'(int'(t_sel - t_stb)), 32'(hc) * 32'h28 + 32'h14);
        check({31'h0, busy}, 32'h0);
        check({8'h0, ext_addr}, 32'h0000_1234);
        if (w) check({16'h0, ext_out}, 32'h0000_a5c3);
        if (!w) check({16'h0, acc_rdata}, 32'h5a3c);
        $display("access code %h mask %h strobe cycles %0d", wc, m, n);
    endtask
    task automatic t_regs;
        reg_chk(4'h0, 32'h0);
        reg_wr(4'h0, 32'h0000_0b41);
        reg_wr(4'h8, 32'h0000_0c00);
        reg_chk(4'h0, 32'h0000_0b41);
        reg_chk(4'h8, 32'h0);
        reg_chk(4'h4, 32'h0);
        $display("test registers done");
    endtask
    task automatic t_wait_table;
        access(1'b0, 4'ha, 1'b1, 2'h0, 8'h03, 8'h0f);
        access(1'b1, 4'hb, 1'b1, 2'h1, 8'h03, 8'h13);
        access(1'b0, 4'hc, 1'b1, 2'h0, 8'h03, 8'h19);
        $display("test wait table done");
    endtask
    task automatic t_ext_wait;
        access(1'b0, 4'h0, 1'b0, 2'h0, 8'h04, 8'h05);
        access(1'b0, 4'h0, 1'b1, 2'h1, 8'h04, 8'h01);
        access(1'b1, 4'h2, 1'b0, 2'h1, 8'h05, 8'h06);
        $display("test external wait done");
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_wait_table();
        t_ext_wait();
        results();
    end
endmodule

// ===== verif/awh_ext_device.sv
// model of the external device: read data while selected and a commanded wait
`timescale 1ns/1ps
module awh_ext_device (
    // bus pins
    input wire logic clk_i,
    input wire logic select_n_i,
    input wire logic strobe_n_i,
    // behaviour set by the bench
    input wire logic [7:0] stall_i,
    input wire logic [15:0] value_i,
    // answer
    output logic [15:0] data_o,
    output logic wait_n_o
);
    logic [7:0] left_q = 8'h00;
    always_ff @(posedge clk_i) begin
        if (strobe_n_i) left_q <= stall_i;
        else if (left_q != 8'h00) left_q <= left_q - 8'h01;
    end
    // wait held low for the commanded cycles from the strobe's start
    assign wait_n_o = !(!strobe_n_i && left_q != 8'h00);
    // deselected: inverted value, so a late sample cannot pass for a match
    assign data_o = select_n_i ? ~value_i : value_i;
endmodule
